/* File: dts_pkg.sv */
package dts_pkg;
  localparam logic [3:0] FIX_TEMP = 4'h3;
  localparam logic [3:0] FIX_STORE = 4'hA;
  localparam logic [3:0] FIX_LOCK = 4'h6;
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam int STORE_DEPTH = 256;
  localparam int UNLOCKED_BIT = 7;
  localparam int LOCK_SET_BIT = 0;
  localparam int TEMP_W = 11;
  localparam int CLK_KHZ = 100000;
  localparam int TIMEOUT_MIN_MS = 25;
  localparam int TIMEOUT_CYC = TIMEOUT_MIN_MS * CLK_KHZ;
  localparam int TMO_W = 22;
  localparam logic [10:0] HYS_0 = 11'h000;
  localparam logic [10:0] HYS_1P5 = 11'h00C;
  localparam logic [10:0] HYS_3 = 11'h018;
  localparam logic [10:0] HYS_6 = 11'h030;
  typedef enum logic [2:0] {
    HYS_OFF = 3'b000,
    HYS_ZERO = 3'b001,
    HYS_ONE5 = 3'b010,
    HYS_THREE = 3'b011,
    HYS_SIX = 3'b100
  } dts_hys_e;
  typedef enum logic [1:0] {
    FN_TEMP = 2'b00,
    FN_STORE = 2'b01,
    FN_LOCK = 2'b10,
    FN_ARA = 2'b11
  } dts_fn_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK_A = 3'b010,
    ST_WR = 3'b011,
    ST_ACK_W = 3'b100,
    ST_RD = 3'b101,
    ST_ACK_R = 3'b110,
    ST_RD_NXT = 3'b111
  } dts_st_e;
endpackage

/* File: dts_thermal.sv */
`timescale 1ns/1ps
module dts_thermal (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [dts_pkg::TEMP_W-1:0] temp_code_in,
  input wire logic [dts_pkg::TEMP_W-1:0] upper_in,
  input wire logic [dts_pkg::TEMP_W-1:0] lower_in,
  input wire logic [dts_pkg::TEMP_W-1:0] crit_in,
  input wire dts_pkg::dts_hys_e hys_sel_in,
  input wire logic alarm_en_in,
  output logic [2:0] status_out,
  output logic event_oe_out
);
  import dts_pkg::*;
  typedef struct packed {
    logic crit;
    logic above;
    logic below;
    logic alarm;
  } dts_th_s;
  dts_th_s cur_ff;
  dts_th_s nxt_th;
  logic signed [11:0] t;
  logic signed [11:0] u;
  logic signed [11:0] l;
  logic signed [11:0] c;
  logic signed [11:0] h;
  logic [10:0] hv;

  always_comb begin
    nxt_th = cur_ff;
    case (hys_sel_in)
      HYS_ONE5: hv = HYS_1P5;
      HYS_THREE: hv = HYS_3;
      HYS_SIX: hv = HYS_6;
      default: hv = HYS_0;
    endcase
    // two's complement, 0.125 degree per step
    t = $signed({temp_code_in[10], temp_code_in});
    u = $signed({upper_in[10], upper_in});
    l = $signed({lower_in[10], lower_in});
    c = $signed({crit_in[10], crit_in});
    h = $signed({1'b0, hv});
    nxt_th.crit = cur_ff.crit ? !(t < c - h) : (t >= c);
    nxt_th.above = cur_ff.above ? !(t <= u - h) : (t > u);
    nxt_th.below = cur_ff.below ? !(t >= l) : (t < l - h);
    nxt_th.alarm = alarm_en_in & (cur_ff.crit | cur_ff.above | cur_ff.below);
    if (!rst_n_in) begin
      nxt_th = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    cur_ff <= nxt_th;
  end

  assign status_out = {cur_ff.crit, cur_ff.above, cur_ff.below};
  assign event_oe_out = cur_ff.alarm;
endmodule

/* File: dts_store.sv */
`timescale 1ns/1ps
module dts_store (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] rd_addr_in,
  input wire logic perm_set_in,
  input wire logic rev_set_in,
  input wire logic rev_clr_in,
  output logic [7:0] rd_data_out,
  output logic permanent_write_lock_out,
  output logic reversible_write_lock_out
);
  import dts_pkg::*;
  typedef struct packed {
    logic [STORE_DEPTH-1:0][7:0] mem;
    logic perm;
    logic rev;
  } dts_store_s;
  dts_store_s cur_ff;
  dts_store_s nxt_st;
  logic wr_ok;

  always_comb begin
    nxt_st = cur_ff;
    // upper half never protected
    wr_ok = wr_addr_in[UNLOCKED_BIT] | ~(cur_ff.perm | cur_ff.rev);
    for (int i = 0; i < STORE_DEPTH; i++) begin
      if (wr_en_in && wr_ok && (wr_addr_in == 8'(i))) begin
        nxt_st.mem[i] = wr_data_in;
      end
    end
    if (perm_set_in) begin
      nxt_st.perm = 1'b1;
    end
    if (rev_set_in) begin
      nxt_st.rev = 1'b1;
    end else if (rev_clr_in && !cur_ff.perm) begin
      nxt_st.rev = 1'b0;
    end
    if (!rst_n_in) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    cur_ff <= nxt_st;
  end

  assign rd_data_out = cur_ff.mem[rd_addr_in];
  assign permanent_write_lock_out = cur_ff.perm;
  assign reversible_write_lock_out = cur_ff.rev;
endmodule

/* File: dts_target.sv */
`timescale 1ns/1ps
module dts_target #(
  parameter int TIMEOUT_CYC = dts_pkg::TIMEOUT_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic scl_clk_in,
  input wire logic scl_pin_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic addr_select_pin_low_in,
  input wire logic addr_select_pin_mid_in,
  input wire logic addr_select_pin_high_in,
  input wire logic hv_detect_in,
  input wire logic timeout_en_in,
  input wire logic alert_pending_in,
  output logic alert_ack_out,
  input wire logic [dts_pkg::TEMP_W-1:0] temp_code_in,
  input wire logic [dts_pkg::TEMP_W-1:0] upper_in,
  input wire logic [dts_pkg::TEMP_W-1:0] lower_in,
  input wire logic [dts_pkg::TEMP_W-1:0] crit_in,
  input wire dts_pkg::dts_hys_e hys_sel_in,
  input wire logic alarm_en_in,
  output logic [2:0] temp_status_out,
  output logic event_oe_out,
  output logic permanent_write_lock_out,
  output logic reversible_write_lock_out
);
  import dts_pkg::*;

  // link side: samples data on each rising clock edge
  typedef struct packed {
    logic bit_v;
  } dts_lk_s;
  dts_lk_s lk_ff;
  dts_lk_s nxt_lk;

  always_comb begin
    nxt_lk.bit_v = sda_in;
  end

  always_ff @(posedge scl_clk_in) begin
    lk_ff <= nxt_lk;
  end

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic [2:0] a_m;
    logic [2:0] a_s;
    logic hv_m;
    logic hv_s;
    dts_st_e st;
    dts_fn_e fn;
    logic rw;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic ack_on;
    logic first;
    logic tbyte;
    logic [7:0] ptr;
    logic [2:0] sel;
    logic hv_lat;
    logic [TMO_W-1:0] tmo;
    logic sda_oe;
    logic sda_lvl;
    logic alert_ack;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic perm_set;
    logic rev_set;
    logic rev_clr;
  } dts_tg_s;
  dts_tg_s cur_ff;
  dts_tg_s nxt_tg;

  logic [7:0] rd_data;
  logic perm_q;
  logic rev_q;
  logic start_ev;
  logic stop_ev;
  logic bit_ev;
  logic fall_ev;
  logic tmo_hit;
  logic load;
  logic [7:0] b;
  logic [7:0] txb;
  logic [15:0] temp_word;
  logic [2:0] th_status;
  logic th_event;

  always_comb begin
    nxt_tg = cur_ff;
    start_ev = cur_ff.scl_s & cur_ff.scl_d & cur_ff.sda_d & ~cur_ff.sda_s;
    stop_ev = cur_ff.scl_s & cur_ff.scl_d & ~cur_ff.sda_d & cur_ff.sda_s;
    // synced clock rise; the captured link bit has long settled by then
    bit_ev = cur_ff.scl_s & ~cur_ff.scl_d;
    fall_ev = cur_ff.scl_d & ~cur_ff.scl_s;
    load = 1'b0;
    b = {cur_ff.sh[6:0], lk_ff.bit_v};
    temp_word = {th_status, temp_code_in, 2'b00};
    case (cur_ff.fn)
      FN_TEMP: txb = cur_ff.tbyte ? temp_word[7:0] : temp_word[15:8];
      FN_STORE: txb = rd_data;
      FN_LOCK: txb = {6'h00, perm_q, rev_q};
      default: txb = {FIX_TEMP, cur_ff.sel, 1'b0};
    endcase
    nxt_tg.scl_m = scl_pin_in;
    nxt_tg.scl_s = cur_ff.scl_m;
    nxt_tg.scl_d = cur_ff.scl_s;
    nxt_tg.sda_m = sda_in;
    nxt_tg.sda_s = cur_ff.sda_m;
    nxt_tg.sda_d = cur_ff.sda_s;
    // pads pull these low when left open
    nxt_tg.a_m = {addr_select_pin_high_in, addr_select_pin_mid_in,
                  addr_select_pin_low_in};
    nxt_tg.a_s = cur_ff.a_m;
    nxt_tg.hv_m = hv_detect_in;
    nxt_tg.hv_s = cur_ff.hv_m;
    nxt_tg.sda_lvl = 1'b0;
    nxt_tg.alert_ack = 1'b0;
    nxt_tg.wr_en = 1'b0;
    nxt_tg.perm_set = 1'b0;
    nxt_tg.rev_set = 1'b0;
    nxt_tg.rev_clr = 1'b0;
    // clock held low too long while busy
    if (cur_ff.st != ST_IDLE && !cur_ff.scl_s) begin
      nxt_tg.tmo = cur_ff.tmo + 1'b1;
    end else begin
      nxt_tg.tmo = '0;
    end
    tmo_hit = timeout_en_in && (cur_ff.tmo >= TMO_W'(TIMEOUT_CYC));
    if (start_ev) begin
      nxt_tg.st = ST_ADDR;
      nxt_tg.cnt = '0;
      nxt_tg.sda_oe = 1'b0;
      nxt_tg.sel = cur_ff.a_s;
      nxt_tg.hv_lat = cur_ff.hv_s;
      nxt_tg.tmo = '0;
    end else if (stop_ev || tmo_hit) begin
      nxt_tg.st = ST_IDLE;
      nxt_tg.sda_oe = 1'b0;
    end else begin
      case (cur_ff.st)
        ST_ADDR: begin
          if (bit_ev) begin
            nxt_tg.sh = b;
            nxt_tg.cnt = cur_ff.cnt + 1'b1;
            if (cur_ff.cnt == 3'h7) begin
              nxt_tg.rw = b[0];
              nxt_tg.st = ST_ACK_A;
              nxt_tg.ack_on = 1'b0;
              nxt_tg.first = 1'b1;
              nxt_tg.tbyte = 1'b0;
              if (b[7:1] == {FIX_TEMP, cur_ff.sel}) begin
                nxt_tg.fn = FN_TEMP;
              end else if (b[7:1] == {FIX_STORE, cur_ff.sel}) begin
                nxt_tg.fn = FN_STORE;
              end else if (b[7:1] == {FIX_LOCK, cur_ff.sel}) begin
                nxt_tg.fn = FN_LOCK;
              end else if (b[7:1] == ARA_ADDR && b[0] && alert_pending_in) begin
                nxt_tg.fn = FN_ARA;
              end else begin
                nxt_tg.st = ST_IDLE;
              end
            end
          end
        end
        ST_ACK_A, ST_ACK_W: begin
          if (fall_ev) begin
            if (!cur_ff.ack_on) begin
              nxt_tg.sda_oe = 1'b1;
              nxt_tg.ack_on = 1'b1;
            end else begin
              nxt_tg.ack_on = 1'b0;
              nxt_tg.sda_oe = 1'b0;
              nxt_tg.cnt = '0;
              if (cur_ff.st == ST_ACK_A && cur_ff.rw) begin
                load = 1'b1;
              end else begin
                nxt_tg.st = ST_WR;
              end
            end
          end
        end
        ST_WR: begin
          if (bit_ev) begin
            nxt_tg.sh = b;
            nxt_tg.cnt = cur_ff.cnt + 1'b1;
            if (cur_ff.cnt == 3'h7) begin
              nxt_tg.st = ST_ACK_W;
              nxt_tg.ack_on = 1'b0;
              nxt_tg.first = 1'b0;
              if (cur_ff.fn == FN_STORE) begin
                if (cur_ff.first) begin
                  nxt_tg.ptr = b;
                end else begin
                  nxt_tg.wr_en = 1'b1;
                  nxt_tg.wr_addr = cur_ff.ptr;
                  nxt_tg.wr_data = b;
                  nxt_tg.ptr = cur_ff.ptr + 1'b1;
                end
              end else if (cur_ff.fn == FN_LOCK) begin
                if (!cur_ff.hv_lat) begin
                  nxt_tg.perm_set = 1'b1;
                end else if (b[LOCK_SET_BIT]) begin
                  nxt_tg.rev_set = 1'b1;
                end else begin
                  nxt_tg.rev_clr = 1'b1;
                end
              end
            end
          end
        end
        ST_RD: begin
          if (fall_ev) begin
            nxt_tg.sda_oe = ~cur_ff.sh[7];
            nxt_tg.sh = {cur_ff.sh[6:0], 1'b0};
          end
          if (bit_ev) begin
            nxt_tg.cnt = cur_ff.cnt + 1'b1;
            if (cur_ff.cnt == 3'h7) begin
              nxt_tg.st = ST_ACK_R;
            end
          end
        end
        ST_ACK_R: begin
          if (fall_ev) begin
            nxt_tg.sda_oe = 1'b0;
          end
          if (bit_ev) begin
            nxt_tg.st = lk_ff.bit_v ? ST_IDLE : ST_RD_NXT;
          end
        end
        ST_RD_NXT: begin
          if (fall_ev) begin
            load = 1'b1;
            nxt_tg.cnt = '0;
          end
        end
        default: begin
          nxt_tg.sda_oe = 1'b0;
        end
      endcase
    end
    if (load) begin
      nxt_tg.st = ST_RD;
      nxt_tg.sda_oe = ~txb[7];
      nxt_tg.sh = {txb[6:0], 1'b0};
      if (cur_ff.fn == FN_STORE) begin
        nxt_tg.ptr = cur_ff.ptr + 1'b1;
      end
      if (cur_ff.fn == FN_TEMP) begin
        nxt_tg.tbyte = ~cur_ff.tbyte;
      end
      if (cur_ff.fn == FN_ARA) begin
        nxt_tg.alert_ack = 1'b1;
      end
    end
    if (!rst_n_in) begin
      nxt_tg = '0;
      nxt_tg.st = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    cur_ff <= nxt_tg;
  end

  dts_store u_store (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(cur_ff.wr_en),
    .wr_addr_in(cur_ff.wr_addr),
    .wr_data_in(cur_ff.wr_data),
    .rd_addr_in(cur_ff.ptr),
    .perm_set_in(cur_ff.perm_set),
    .rev_set_in(cur_ff.rev_set),
    .rev_clr_in(cur_ff.rev_clr),
    .rd_data_out(rd_data),
    .permanent_write_lock_out(perm_q),
    .reversible_write_lock_out(rev_q)
  );

  dts_thermal u_thermal (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .temp_code_in(temp_code_in),
    .upper_in(upper_in),
    .lower_in(lower_in),
    .crit_in(crit_in),
    .hys_sel_in(hys_sel_in),
    .alarm_en_in(alarm_en_in),
    .status_out(th_status),
    .event_oe_out(th_event)
  );

  assign sda_out = cur_ff.sda_lvl;
  assign sda_oe_out = cur_ff.sda_oe;
  assign alert_ack_out = cur_ff.alert_ack;
  assign temp_status_out = th_status;
  assign event_oe_out = th_event;
  assign permanent_write_lock_out = perm_q;
  assign reversible_write_lock_out = rev_q;
endmodule

/* File: dts_host_model.sv */
`timescale 1ns/1ps
module dts_host_model (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  logic tick;
  initial begin
    tick = 1'b0;
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
    #3;
    forever #6 tick = ~tick;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge tick);
  endtask
  // clock only moves inside frames
  task automatic start();
    wt(2);
    sda_pull_out = 1'b0;
    wt(9);
    scl_out = 1'b1;
    wt(9);
    sda_pull_out = 1'b1;
    wt(9);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    wt(2);
    sda_pull_out = 1'b1;
    wt(9);
    scl_out = 1'b1;
    wt(9);
    sda_pull_out = 1'b0;
    wt(9);
  endtask
  // data moves while clock low, sampled late in high phase
  task automatic bit_xfer(input logic b, output logic r);
    wt(2);
    sda_pull_out = ~b;
    wt(9);
    scl_out = 1'b1;
    wt(9);
    r = sda_in;
    scl_out = 1'b0;
  endtask
  // top bit first, then the acknowledge slot
  task automatic byte_xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                           output logic na);
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], q[i]);
    bit_xfer(ai, na);
  endtask
endmodule

/* File: dts_target_properties.sv */
`timescale 1ns/1ps
module dts_chk #(
  parameter int TIMEOUT_CYC = 200
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic scl_pin_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic hv_detect_in,
  input wire logic timeout_en_in,
  input wire logic alert_pending_in,
  input wire logic alert_ack_out,
  input wire logic [dts_pkg::TEMP_W-1:0] temp_code_in,
  input wire logic [dts_pkg::TEMP_W-1:0] upper_in,
  input wire logic [dts_pkg::TEMP_W-1:0] crit_in,
  input wire logic alarm_en_in,
  input wire logic [2:0] temp_status_out,
  input wire logic event_oe_out,
  input wire logic permanent_write_lock_out,
  input wire logic reversible_write_lock_out
);
  import dts_pkg::*;
  int low_cnt_ff;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || scl_pin_in || !timeout_en_in) begin
      low_cnt_ff <= 0;
    end else if (low_cnt_ff < TIMEOUT_CYC + 8) begin
      low_cnt_ff <= low_cnt_ff + 1;
    end
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  sda_low_only_a: assert property (sda_oe_out |-> !sda_out)
    else $error("data line driven high");
  oe_scl_low_a: assert property ($changed(sda_oe_out) |-> !scl_pin_in)
    else $error("data line moved while clock high");
  tmo_release_a: assert property (low_cnt_ff == TIMEOUT_CYC + 8 |-> !sda_oe_out)
    else $error("stalled transfer not released");
  crit_trip_a: assert property ($stable(temp_code_in) && $stable(crit_in)
    && ($signed(temp_code_in) >= $signed(crit_in)) |=> temp_status_out[2])
    else $error("critical flag missing");
  above_trip_a: assert property ($stable(temp_code_in) && $stable(upper_in)
    && ($signed(temp_code_in) > $signed(upper_in)) |=> temp_status_out[1])
    else $error("above flag missing");
  event_out_a: assert property (temp_status_out != 3'h0 && alarm_en_in ##1 alarm_en_in
    |-> event_oe_out)
    else $error("alarm output missing");
  perm_sticky_a: assert property (!$fell(permanent_write_lock_out))
    else $error("permanent lock cleared");
  rev_refused_a: assert property (permanent_write_lock_out && reversible_write_lock_out
    |=> reversible_write_lock_out)
    else $error("reversible lock cleared under permanent lock");
  rev_needs_hv_a: assert property ($rose(reversible_write_lock_out)
    |-> $past(hv_detect_in, 8))
    else $error("reversible lock without high voltage");
  perm_low_hv_a: assert property ($rose(permanent_write_lock_out)
    |-> !$past(hv_detect_in, 8))
    else $error("permanent lock with high voltage");
  alert_pulse_a: assert property (alert_ack_out |-> $past(alert_pending_in, 4)
    ##1 !alert_ack_out)
    else $error("alert answer without pending alert");
  cover property ($rose(reversible_write_lock_out));
  cover property ($rose(permanent_write_lock_out));
  cover property (alert_ack_out);
  cover property (low_cnt_ff == TIMEOUT_CYC + 8);
  cover property ($rose(event_oe_out));
endmodule
bind dts_target dts_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) dts_chk_inst (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .scl_pin_in(scl_pin_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .hv_detect_in(hv_detect_in), .timeout_en_in(timeout_en_in),
  .alert_pending_in(alert_pending_in), .alert_ack_out(alert_ack_out),
  .temp_code_in(temp_code_in), .upper_in(upper_in), .crit_in(crit_in),
  .alarm_en_in(alarm_en_in), .temp_status_out(temp_status_out), .event_oe_out(event_oe_out),
  .permanent_write_lock_out(permanent_write_lock_out),
  .reversible_write_lock_out(reversible_write_lock_out));

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  import dts_pkg::*;
  logic clk_sys_in, rst_n_in, scl, pull, sda, sda_out, sda_oe_out, alert_ack_out, ev;
  logic perm, rev, hv, tmo_en, alert, alarm_en, q_bit, m_perm, m_rev;
  logic [2:0] pins, status;
  logic [10:0] temp, upper, lower, crit;
  logic [7:0] q;
  logic [7:0] mem [256];
  dts_hys_e hys;
  int seed = 55;
  int mismatches = 0;
  int samples_checked = 0;
  int acks = 0;
  assign sda = ~(pull | (sda_oe_out & ~sda_out));
  dts_target #(.TIMEOUT_CYC(200)) dts_target_inst (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .scl_clk_in(scl), .scl_pin_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .addr_select_pin_low_in(pins[0]), .addr_select_pin_mid_in(pins[1]),
    .addr_select_pin_high_in(pins[2]), .hv_detect_in(hv), .timeout_en_in(tmo_en),
    .alert_pending_in(alert), .alert_ack_out(alert_ack_out), .temp_code_in(temp),
    .upper_in(upper), .lower_in(lower), .crit_in(crit), .hys_sel_in(hys),
    .alarm_en_in(alarm_en), .temp_status_out(status), .event_oe_out(ev),
    .permanent_write_lock_out(perm), .reversible_write_lock_out(rev));
  dts_host_model dts_host_model_inst (.sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) if (alert_ack_out === 1'b1) acks++;
  task automatic final_report();
    $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic [2:0] got, input logic [2:0] exp);
    chk_byte({5'h00, got}, {5'h00, exp});
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic addr(input logic [3:0] f, input logic rd, input logic ok);
    logic a;
    dts_host_model_inst.start();
    dts_host_model_inst.byte_xfer({f, pins, rd}, 1'b1, q, a);
    chk_flag({2'b00, a}, {2'b00, ~ok});
  endtask
  task automatic rd_byte(input logic last, input logic [7:0] exp);
    logic a;
    dts_host_model_inst.byte_xfer(8'hFF, last, q, a);
    chk_byte(q, exp);
  endtask
  task automatic wr_byte(input logic [7:0] d);
    logic a;
    dts_host_model_inst.byte_xfer(d, 1'b1, q, a);
    chk_flag({2'b00, a}, 3'h0);
  endtask
  task automatic store_test(input logic [7:0] p);
    logic [7:0] d;
    addr(FIX_STORE, 1'b0, 1'b1);
    wr_byte(p);
    for (int i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      wr_byte(d);
      if (8'(p + i) >= 8'h80 || !(m_perm || m_rev)) mem[8'(p + i)] = d;
    end
    addr(FIX_STORE, 1'b0, 1'b1);
    wr_byte(p);
    addr(FIX_STORE, 1'b1, 1'b1);
    for (int i = 0; i < 3; i++) rd_byte(i == 2, mem[8'(p + i)]);
    dts_host_model_inst.stop();
  endtask
  task automatic lock_step(input logic h, input logic [7:0] d);
    tk(1);
    hv = h;
    addr(FIX_LOCK, 1'b0, 1'b1);
    wr_byte(d);
    dts_host_model_inst.stop();
    if (!h) m_perm = 1'b1;
    else if (d[0]) m_rev = 1'b1;
    else if (!m_perm) m_rev = 1'b0;
    tk(4);
    chk_flag({1'b0, perm, rev}, {1'b0, m_perm, m_rev});
    addr(FIX_LOCK, 1'b1, 1'b1);
    rd_byte(1'b1, {6'h00, m_perm, m_rev});
    dts_host_model_inst.stop();
    store_test(8'h7E);
    store_test(8'hFE);
  endtask
  task automatic sensor_test(input dts_hys_e h);
    logic [2:0] st;
    tk(1);
    hys = h;
    temp = 11'($random(seed));
    upper = 11'($random(seed));
    lower = 11'($random(seed));
    crit = 11'($random(seed));
    alarm_en = 1'($random(seed));
    st = {$signed(temp) >= $signed(crit), $signed(temp) > $signed(upper),
          $signed(temp) < $signed(lower)};
    tk(3);
    chk_flag(status, st);
    chk_flag({2'b00, ev}, {2'b00, alarm_en & (|st)});
    addr(FIX_TEMP, 1'b1, 1'b1);
    rd_byte(1'b0, {st, temp[10:6]});
    rd_byte(1'b1, {temp[5:0], 2'b00});
    dts_host_model_inst.stop();
  endtask
  task automatic hys_test(input dts_hys_e h, input int steps);
    tk(1);
    hys = h;
    alarm_en = 1'b0;
    {temp, upper, lower, crit} = {11'h200, 11'h100, 11'h000, 11'h200};
    tk(3);
    chk_flag(status, 3'h6);
    temp = 11'(512 - steps + 1);
    tk(3);
    chk_flag(status, 3'h6);
    temp = 11'(512 - steps - 1);
    tk(3);
    chk_flag(status, 3'h2);
  endtask
  initial begin
    {rst_n_in, hv, tmo_en, alert, alarm_en, pins, m_perm, m_rev} = 10'h000;
    {temp, upper, lower, crit} = 44'h0;
    hys = HYS_OFF;
    foreach (mem[i]) mem[i] = 8'h00;
    tk(4);
    rst_n_in = 1'b1;
    tk(4);
    for (int f = 0; f < 16; f++) begin
      tk(1);
      pins = 3'($random(seed));
      addr(4'(f), 1'b0, 4'(f) inside {FIX_TEMP, FIX_STORE, FIX_LOCK});
      dts_host_model_inst.stop();
    end
    for (int a = 0; a < 2; a++) begin
      tk(1);
      alert = a[0];
      pins = 3'($random(seed));
      dts_host_model_inst.start();
      dts_host_model_inst.byte_xfer({ARA_ADDR, 1'b1}, 1'b1, q, q_bit);
      chk_flag({2'b00, q_bit}, {2'b00, ~alert});
      if (alert) rd_byte(1'b1, {FIX_TEMP, pins, 1'b0});
      dts_host_model_inst.stop();
    end
    chk_flag(acks[2:0], 3'h1);
    tk(1);
    tmo_en = 1'b1;
    dts_host_model_inst.start();
    q = {FIX_STORE, pins, 1'b0};
    for (int i = 7; i >= 0; i--) dts_host_model_inst.bit_xfer(q[i], q_bit);
    tk(150);
    chk_flag({2'b00, sda_oe_out}, 3'h1);
    tk(120);
    chk_flag({2'b00, sda_oe_out}, 3'h0);
    dts_host_model_inst.stop();
    lock_step(1'b1, 8'h01);
    lock_step(1'b1, 8'h00);
    lock_step(1'b1, 8'h01);
    lock_step(1'b0, 8'h5A);
    lock_step(1'b1, 8'h00);
    for (int i = 0; i < 6; i++) sensor_test(i[0] ? HYS_ZERO : HYS_OFF);
    hys_test(HYS_ONE5, 12);
    hys_test(HYS_THREE, 24);
    hys_test(HYS_SIX, 48);
    final_report();
  end
  initial begin
    #700000;
    mismatches++;
    final_report();
  end
endmodule
